// ==== src/timer16_clock_force_irq_regs.sv ====
// 16-bit timer register slice: clock select, shared byte latch, compares, capture, irq masks
//
// Notes on behaviour
// (R1) clock selector: stop, io clock, /8,/64,/256,/1024, external falling or rising edge
// (R2) external pin edges count even when the port drives that pin as output
// (R3) force strobes at bits 7,6,5 act only in non-PWM waveform modes
// (R4) a force strobe makes an immediate match; pin follows current output field
// (R5) a forced match sets no flag and never clears the counter
// (R6) force strobe bits hold nothing and always read zero
// (R7) software writes zero to bits 4:0 of the force control register
// (R8) counter is two bytes moved together through one shared high-byte latch
// (R9) a counter write blocks every compare match on the next timer tick
// (R10) software avoids changing a running counter, a match may be skipped
// (R11) each compare word is checked against the counter on every timer tick
// (R12) compare writes go through the shared latch, both bytes land together
// (R13) capture loads counter on a qualifying pin or comparator event
// (R14) capture word can serve as counter top in modes selecting it
// (R15) capture reads use the shared latch so both bytes match
// (R16) first timer mask bits 5..2 gate flags with the global enable
// (R17) second timer mask bits 5..1 gate extended flags with the global enable
// (R18) software writes zero to bits 7:6 of the extended mask
// (R19) extended mask is absent in legacy compatibility mode
// (R20) normal and clear-on-match modes are the non-PWM modes
// (R21) compare flag sets on the timer tick after counter equals compare
// (R22) flags clear on service or by writing one to the bit
// (R23) write high byte then low commits; low read latches high for next read
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module timer16_clock_force_irq_regs
    import timer16_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic externalCountPin,
    input wire logic capturePin,
    input wire logic comparatorOut,
    input wire logic comparatorSelect,
    input wire logic globalIrqEnable,
    input wire logic legacyMode,
    input wire t1_irq_t t1Events,
    input wire t1_irq_t t1Service,
    input wire t3_irq_t t3Service,
    output t1_irq_t t1IrqReq,
    output t3_irq_t t3IrqReq,
    output logic [2:0] compareOutputPin
);
    localparam int CHANNELS = 3;

    logic [1:0] extSync;
    logic [1:0] capSync;
    logic [1:0] cmpSync;
    logic extPrev;
    logic srcPrev;
    logic [7:0] ctrlAReg;
    logic [7:0] ctrlBReg;
    logic [7:0] tempReg;
    logic [15:0] counterReg;
    logic [15:0] capReg;
    logic [9:0] prescReg;
    logic blockReg;
    t1_irq_t maskT1Reg;
    t3_irq_t maskT3Reg;
    t1_irq_t flagT1Reg;
    t3_irq_t flagT3Reg;
    logic [7:0] rdNext;
    logic [15:0] topValue;
    logic [15:0] cmpValue [0:CHANNELS-1];
    logic [CHANNELS-1:0] matchNow;
    logic [CHANNELS-1:0] matchSet;
    logic [CHANNELS-1:0] forceHit;
    logic [3:0] wgm;
    logic [2:0] clkSel;
    logic tick;
    logic nonPwm;
    logic capTop;
    logic atTop;
    logic cntWrite;
    logic capSrc;
    logic capEvent;
    logic capFlagSet;
    logic ovfEvent;

    assign wgm = {ctrlBReg[WGM_HI_LSB +: 2], ctrlAReg[1:0]};
    assign clkSel = ctrlBReg[CLK_SEL_LSB +: 3];
    assign nonPwm = (wgm == WGM_NORMAL) || (wgm == WGM_CTC_CMP) || (wgm == WGM_CTC_CAP); // [R20] [R3]
    assign capTop = wgm[3] && !wgm[0]; // [R14]
    assign cntWrite = regWrite && (regAddr == ADDR_CNT_LO);
    assign atTop = (counterReg == topValue);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // the count pin is sampled regardless of port direction, so software may toggle it
    always_ff @(posedge clk) begin
        if (reset) begin
            extSync <= 2'h0;
            capSync <= 2'h0;
            cmpSync <= 2'h0;
            extPrev <= 1'b0;
            srcPrev <= 1'b0;
        end else begin
            extSync <= {extSync[0], externalCountPin}; // [R2]
            capSync <= {capSync[0], capturePin};
            cmpSync <= {cmpSync[0], comparatorOut};
            extPrev <= extSync[1];
            srcPrev <= capSrc;
        end
    end

    // ----------------------------------------------------------------
    // clock source and prescaler
    // ----------------------------------------------------------------
    // free-running prescaler: a tick is one io clock wide, phase is not reset on selection
    always_ff @(posedge clk) begin
        if (reset) begin
            prescReg <= 10'h000;
        end else begin
            prescReg <= prescReg + 10'h001;
        end
    end

    // tick selection [R1]
    always_comb begin
        unique case (clkSel)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (prescReg & PRE_MASK8) == PRE_MASK8;
            CS_DIV64: tick = (prescReg & PRE_MASK64) == PRE_MASK64;
            CS_DIV256: tick = (prescReg & PRE_MASK256) == PRE_MASK256;
            CS_DIV1024: tick = (prescReg & PRE_MASK1024) == PRE_MASK1024;
            CS_EXT_FALL: tick = extPrev && !extSync[1];
            CS_EXT_RISE: tick = !extPrev && extSync[1];
        endcase
    end

    // counter top per waveform mode; reserved mode runs to the maximum
    always_comb begin
        unique case (wgm)
            4'h1, 4'h5: topValue = TOP_8BIT;
            4'h2, 4'h6: topValue = TOP_9BIT;
            4'h3, 4'h7: topValue = TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: topValue = cmpValue[0];
            4'h8, 4'ha, 4'hc, 4'he: topValue = capReg; // [R14]
            default: topValue = TOP_MAX;
        endcase
    end

    // ----------------------------------------------------------------
    // counter, byte latch and match blocking
    // ----------------------------------------------------------------
    // software write wins over a tick; pwm modes only count upward here
    always_ff @(posedge clk) begin
        if (reset) begin
            counterReg <= RESET_WORD;
        end else if (cntWrite) begin
            counterReg <= {tempReg, regWdata}; // [R8] [R23]
        end else if (tick) begin
            counterReg <= atTop ? RESET_WORD : counterReg + 16'h0001;
        end
    end

    // a counter write holds off matches until the next tick has passed
    always_ff @(posedge clk) begin
        if (reset) begin
            blockReg <= 1'b0;
        end else if (cntWrite) begin
            blockReg <= 1'b1; // [R9]
        end else if (tick) begin
            blockReg <= 1'b0;
        end
    end

    // one latch for every 16-bit word: high write fills it, a counter or capture low read loads it
    always_ff @(posedge clk) begin
        if (reset) begin
            tempReg <= RESET_BYTE;
        end else if (regWrite && (regAddr == ADDR_CNT_HI || regAddr == ADDR_CAP_HI
                || regAddr == ADDR_CMP_HI[0] || regAddr == ADDR_CMP_HI[1] || regAddr == ADDR_CMP_HI[2])) begin
            tempReg <= regWdata; // [R23] [R12]
        end else if (regRead && regAddr == ADDR_CNT_LO) begin
            tempReg <= counterReg[15:8]; // [R8]
        end else if (regRead && regAddr == ADDR_CAP_LO) begin
            tempReg <= capReg[15:8]; // [R15]
        end
    end

    // ----------------------------------------------------------------
    // compare channels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < CHANNELS; i++) begin : gChan
        logic [15:0] valueR;
        logic pendR;
        logic pinR;
        logic [1:0] com;

        assign com = ctrlAReg[COM_LSB[i] +: 2];
        assign cmpValue[i] = valueR;
        assign matchNow[i] = tick && (counterReg == valueR) && !blockReg; // [R11] [R9]
        assign matchSet[i] = tick && pendR; // [R21]
        assign forceHit[i] = regWrite && (regAddr == ADDR_CTRL_C) && regWdata[FORCE_BIT[i]] && nonPwm; // [R3]
        assign compareOutputPin[i] = pinR;

        // compare word commits both bytes on the low write
        always_ff @(posedge clk) begin
            if (reset) begin
                valueR <= RESET_WORD;
            end else if (regWrite && regAddr == ADDR_CMP_LO[i]) begin
                valueR <= {tempReg, regWdata}; // [R12]
            end
        end

        // the flag lags the equality by one timer tick
        always_ff @(posedge clk) begin
            if (reset) begin
                pendR <= 1'b0;
            end else if (tick) begin
                pendR <= matchNow[i]; // [R21]
            end
        end

        // pin logic covers non-pwm actions; pwm waveforms are outside this slice
        always_ff @(posedge clk) begin
            if (reset) begin
                pinR <= 1'b0;
            end else if (forceHit[i] || (matchNow[i] && nonPwm)) begin
                unique case (com) // [R4]
                    COM_OFF: pinR <= pinR;
                    COM_TOGGLE: pinR <= !pinR;
                    COM_CLEAR: pinR <= 1'b0;
                    COM_SET: pinR <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // capture
    // ----------------------------------------------------------------
    assign capSrc = comparatorSelect ? cmpSync[1] : capSync[1]; // [R13]
    assign capEvent = !capTop && (ctrlBReg[EDGE_SEL_BIT] ? (capSrc && !srcPrev) : (!capSrc && srcPrev));
    assign capFlagSet = capEvent || (capTop && tick && atTop);
    assign ovfEvent = tick && (nonPwm ? counterReg == TOP_MAX : atTop);

    // a software write wins over a simultaneous capture
    always_ff @(posedge clk) begin
        if (reset) begin
            capReg <= RESET_WORD;
        end else if (regWrite && regAddr == ADDR_CAP_LO) begin
            capReg <= {tempReg, regWdata};
        end else if (capEvent) begin
            capReg <= counterReg; // [R13]
        end
    end

    // ----------------------------------------------------------------
    // control, masks, flags and requests
    // ----------------------------------------------------------------
    // force bits are strobes: nothing of the force register is stored [R6] [R7]
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlAReg <= RESET_BYTE;
            ctrlBReg <= RESET_BYTE;
            maskT1Reg <= '0;
            maskT3Reg <= '0;
        end else if (regWrite) begin
            if (regAddr == ADDR_CTRL_A) ctrlAReg <= regWdata;
            if (regAddr == ADDR_CTRL_B) ctrlBReg <= regWdata & 8'hdf;
            if (regAddr == ADDR_MASK_T1) maskT1Reg <= regWdata[T1_FIELD_LSB +: 4]; // [R16]
            if (regAddr == ADDR_MASK_T3 && !legacyMode) maskT3Reg <= regWdata[T3_FIELD_LSB +: 5]; // [R17] [R19]
        end
    end

    // set wins over clear; forced matches never reach the set terms [R5] [R22]
    always_ff @(posedge clk) begin
        if (reset) begin
            flagT1Reg <= '0;
            flagT3Reg <= '0;
        end else begin
            flagT1Reg <= (flagT1Reg & ~(t1Service | ((regWrite && regAddr == ADDR_FLAG_T1)
                ? regWdata[T1_FIELD_LSB +: 4] : 4'h0))) | t1Events;
            flagT3Reg <= (flagT3Reg & ~(t3Service | ((regWrite && regAddr == ADDR_FLAG_T3)
                ? regWdata[T3_FIELD_LSB +: 5] : 5'h00)))
                | {capFlagSet, matchSet[0], matchSet[1], ovfEvent, matchSet[2]};
        end
    end

    // requests are registered; the extended mask counts as clear in legacy mode
    always_ff @(posedge clk) begin
        if (reset) begin
            t1IrqReq <= '0;
            t3IrqReq <= '0;
        end else begin
            t1IrqReq <= flagT1Reg & maskT1Reg & {4{globalIrqEnable}}; // [R16]
            t3IrqReq <= flagT3Reg & maskT3Reg & {5{globalIrqEnable && !legacyMode}}; // [R17] [R19]
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rdNext = RESET_BYTE;
        unique case (regAddr)
            ADDR_FLAG_T1: rdNext = {2'h0, flagT1Reg, 2'h0};
            ADDR_MASK_T1: rdNext = {2'h0, maskT1Reg, 2'h0};
            ADDR_FLAG_T3: rdNext = {2'h0, flagT3Reg, 1'b0};
            ADDR_MASK_T3: rdNext = legacyMode ? RESET_BYTE : {2'h0, maskT3Reg, 1'b0}; // [R19]
            ADDR_CTRL_A: rdNext = ctrlAReg;
            ADDR_CTRL_B: rdNext = ctrlBReg;
            ADDR_CTRL_C: rdNext = RESET_BYTE; // [R6]
            ADDR_CNT_LO: rdNext = counterReg[7:0];
            ADDR_CNT_HI: rdNext = tempReg; // [R23]
            ADDR_CAP_LO: rdNext = capReg[7:0];
            ADDR_CAP_HI: rdNext = tempReg; // [R15]
            ADDR_CMP_LO[0]: rdNext = cmpValue[0][7:0];
            ADDR_CMP_HI[0]: rdNext = cmpValue[0][15:8];
            ADDR_CMP_LO[1]: rdNext = cmpValue[1][7:0];
            ADDR_CMP_HI[1]: rdNext = cmpValue[1][15:8];
            ADDR_CMP_LO[2]: rdNext = cmpValue[2][7:0];
            ADDR_CMP_HI[2]: rdNext = cmpValue[2][15:8];
            default: rdNext = RESET_BYTE;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            regRdata <= RESET_BYTE;
        end else begin
            regRdata <= regRead ? rdNext : RESET_BYTE;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_stop_holds: assert property ( // [R1]
        (clkSel == CS_STOP && !cntWrite) |=> $stable(counterReg))
        else $error("counter moved while stopped");
    a_tick_counts: assert property ( // [R1]
        (tick && !cntWrite) |=> counterReg == ($past(atTop) ? 16'h0000 : $past(counterReg) + 16'h0001))
        else $error("counter did not advance on tick");
    a_force_reads_zero: assert property ( // [R6]
        (regRead && regAddr == ADDR_CTRL_C) |=> regRdata == 8'h00)
        else $error("force register read nonzero");
    a_force_sets_pin: assert property ( // [R4]
        (forceHit[0] && ctrlAReg[7:6] == COM_SET) |=> compareOutputPin[0])
        else $error("forced match did not set pin");
    a_pwm_force_ignored: assert property ( // [R3]
        (regWrite && regAddr == ADDR_CTRL_C && !nonPwm) |=> $stable(compareOutputPin))
        else $error("force acted in pwm mode");
    a_force_no_flag: assert property ( // [R5]
        (forceHit[0] && !flagT3Reg.matchA && !gChan[0].pendR) |=> !flagT3Reg.matchA)
        else $error("forced match set a flag");
    a_write_blocks_match: assert property ( // [R9]
        (cntWrite && clkSel == CS_DIV1) |=> matchNow == 3'h0)
        else $error("match not blocked after counter write");
    a_flag_after_match: assert property ( // [R21]
        (matchNow[0] ##1 tick) |=> flagT3Reg.matchA)
        else $error("compare flag not set on following tick");
    a_word_commit: assert property ( // [R8]
        (regWrite && regAddr == ADDR_CNT_HI ##1 !regWrite ##1 cntWrite)
        |=> counterReg == {$past(regWdata, 3), $past(regWdata)})
        else $error("counter word not committed atomically");
    a_capture_load: assert property ( // [R13]
        (capEvent && !(regWrite && regAddr == ADDR_CAP_LO)) |=> capReg == $past(counterReg))
        else $error("capture missed counter value");
    a_t1_irq_gate: assert property ( // [R16]
        t1IrqReq.overflow |-> $past(flagT1Reg.overflow && maskT1Reg.overflow && globalIrqEnable))
        else $error("t1 request without enable");
    a_t3_irq_gate: assert property ( // [R17]
        t3IrqReq.matchA |-> $past(flagT3Reg.matchA && maskT3Reg.matchA && globalIrqEnable && !legacyMode))
        else $error("t3 request without enable");
    a_legacy_mask_absent: assert property ( // [R19]
        (legacyMode && regRead && regAddr == ADDR_MASK_T3) |=> regRdata == 8'h00)
        else $error("extended mask visible in legacy mode");
    a_service_clears: assert property ( // [R22]
        (t3Service.matchA && !matchSet[0]) |=> !flagT3Reg.matchA)
        else $error("serviced flag not cleared");

    c_force_event: cover property (forceHit[0]);
    c_capture_event: cover property (capEvent);
    c_match_irq: cover property (t3IrqReq.matchA);
    c_ext_tick: cover property (clkSel == CS_EXT_RISE && tick);
endmodule // timer16_clock_force_irq_regs

`default_nettype wire

// ==== src/timer16_pkg.sv ====
// shared constants and carrier types for the 16-bit timer register slice
package timer16_pkg;
    // register addresses
    localparam logic [7:0] ADDR_FLAG_T1 = 8'h36;
    localparam logic [7:0] ADDR_MASK_T1 = 8'h37;
    localparam logic [7:0] ADDR_FLAG_T3 = 8'h7c;
    localparam logic [7:0] ADDR_MASK_T3 = 8'h7d;
    localparam logic [7:0] ADDR_CAP_LO = 8'h80;
    localparam logic [7:0] ADDR_CAP_HI = 8'h81;
    localparam logic [7:0] ADDR_CMP_LO [0:2] = '{8'h86, 8'h84, 8'h82};
    localparam logic [7:0] ADDR_CMP_HI [0:2] = '{8'h87, 8'h85, 8'h83};
    localparam logic [7:0] ADDR_CNT_LO = 8'h88;
    localparam logic [7:0] ADDR_CNT_HI = 8'h89;
    localparam logic [7:0] ADDR_CTRL_B = 8'h8a;
    localparam logic [7:0] ADDR_CTRL_A = 8'h8b;
    localparam logic [7:0] ADDR_CTRL_C = 8'h8c;
    // field positions
    localparam int T1_FIELD_LSB = 2;
    localparam int T3_FIELD_LSB = 1;
    localparam int EDGE_SEL_BIT = 6;
    localparam int WGM_HI_LSB = 3;
    localparam int CLK_SEL_LSB = 0;
    localparam int FORCE_BIT [0:2] = '{7, 6, 5};
    localparam int COM_LSB [0:2] = '{6, 4, 2};
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // clock source codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // prescaler terminal masks (divide by 8, 64, 256, 1024)
    localparam logic [9:0] PRE_MASK8 = 10'h007;
    localparam logic [9:0] PRE_MASK64 = 10'h03f;
    localparam logic [9:0] PRE_MASK256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK1024 = 10'h3ff;
    // waveform modes and fixed tops
    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CTC_CMP = 4'h4;
    localparam logic [3:0] WGM_CTC_CAP = 4'hc;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] TOP_MAX = 16'hffff;
    // compare output actions
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef struct packed {
        logic capture;
        logic matchA;
        logic matchB;
        logic overflow;
    } t1_irq_t;

    typedef struct packed {
        logic capture;
        logic matchA;
        logic matchB;
        logic overflow;
        logic matchC;
    } t3_irq_t;
endpackage

// ==== verification/tb_top.sv ====
// self-checking testbench for the 16-bit timer register slice
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import timer16_pkg::*;
    // ----
    // signals and instance
    // ----
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdata;
    logic externalCountPin = 1'b0;
    logic capturePin = 1'b0;
    logic comparatorOut = 1'b0;
    logic comparatorSelect = 1'b0;
    logic globalIrqEnable = 1'b0;
    logic legacyMode = 1'b0;
    t1_irq_t t1Events = '0;
    t1_irq_t t1Service = '0;
    t3_irq_t t3Service = '0;
    t1_irq_t t1IrqReq;
    t3_irq_t t3IrqReq;
    logic [2:0] compareOutputPin;
    logic [7:0] expQ [$];
    logic rdPend = 1'b0;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 32'he2e7;
    int divs [6] = '{4, 1, 8, 64, 256, 1024};
    logic [15:0] val;
    logic [7:0] got;

    timer16_clock_force_irq_regs i_dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .externalCountPin(externalCountPin),
        .capturePin(capturePin), .comparatorOut(comparatorOut), .comparatorSelect(comparatorSelect),
        .globalIrqEnable(globalIrqEnable), .legacyMode(legacyMode), .t1Events(t1Events),
        .t1Service(t1Service), .t3Service(t3Service), .t1IrqReq(t1IrqReq), .t3IrqReq(t3IrqReq),
        .compareOutputPin(compareOutputPin));

    always #25 clk = ~clk;

    // hang guard, generous against roughly 5800 cycles of traffic
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    // read data stands only in the cycle after the strobe; oldest note is the expectation
    always @(posedge clk) begin
        if (rdPend && expQ.size() > 0) begin
            check({8'h00, regRdata}, {8'h00, expQ.pop_front()});
        end
        rdPend <= regRead;
    end

    // ----
    // bus tasks and reporting
    // ----
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        regRead <= 1'b0;
    endtask
    // direct sample for range checks; the extra edge keeps the note queue out of step races
    task automatic peek(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 v = regRdata;
        @(posedge clk);
    endtask
    // high byte first loads the shared latch, low byte commits
    task automatic wrw(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic fin(input string n);
        $display("test %s done", n);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_MASK_T1, 8'h00);
        rd(ADDR_MASK_T3, 8'h00);
        wr(ADDR_CTRL_C, 8'he0);
        rd(ADDR_CTRL_C, 8'h00);
        rd(8'hf0, 8'h00);
        val = 16'($random(seed));
        wrw(ADDR_CNT_HI, ADDR_CNT_LO, val);
        rd(ADDR_CNT_LO, val[7:0]);
        rd(ADDR_CNT_HI, val[15:8]);
        wr(ADDR_CNT_HI, 8'hab);
        wr(ADDR_CMP_LO[1], 8'h11);
        rd(ADDR_CMP_LO[1], 8'h11);
        rd(ADDR_CMP_HI[1], 8'hab);
        wr(ADDR_MASK_T1, 8'hff);
        rd(ADDR_MASK_T1, 8'h3c);
        wr(ADDR_MASK_T3, 8'h3e);
        rd(ADDR_MASK_T3, 8'h3e);
        legacyMode <= 1'b1;
        rd(ADDR_MASK_T3, 8'h00);
        legacyMode <= 1'b0;
        fin("latch and masks");
        // each first-timer source: raise, gate globally, clear by service or write-one
        globalIrqEnable <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            wr(ADDR_MASK_T1, 8'(1 << (b + 2)));
            t1Events <= t1_irq_t'(4'(1 << b));
            @(posedge clk);
            t1Events <= '0;
            pause(3);
            check({12'h000, t1IrqReq}, 16'(1 << b));
            rd(ADDR_FLAG_T1, 8'(1 << (b + 2)));
            globalIrqEnable <= 1'b0;
            pause(3);
            check({12'h000, t1IrqReq}, 16'h0000);
            globalIrqEnable <= 1'b1;
            if (b[0]) begin
                t1Service <= t1_irq_t'(4'(1 << b));
                @(posedge clk);
                t1Service <= '0;
            end else begin
                wr(ADDR_FLAG_T1, 8'(1 << (b + 2)));
            end
            pause(3);
            check({12'h000, t1IrqReq}, 16'h0000);
        end
        fin("t1 irq");
        // running match at io clock rate: pin, flag and request
        wr(ADDR_MASK_T3, 8'h10);
        wrw(ADDR_CMP_HI[0], ADDR_CMP_LO[0], 16'h0010);
        wrw(ADDR_CNT_HI, ADDR_CNT_LO, 16'h0000);
        wr(ADDR_CTRL_A, 8'hc0);
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        wrw(ADDR_CNT_HI, ADDR_CNT_LO, 16'h0000);
        pause(30);
        wr(ADDR_CTRL_B, 8'h00);
        check({13'h0000, compareOutputPin}, 16'h0001);
        check({11'h000, t3IrqReq}, 16'h0008);
        rd(ADDR_FLAG_T3, 8'h10);
        legacyMode <= 1'b1;
        pause(3);
        check({11'h000, t3IrqReq}, 16'h0000);
        legacyMode <= 1'b0;
        t3Service <= t3_irq_t'(5'h08);
        @(posedge clk);
        t3Service <= '0;
        pause(3);
        check({11'h000, t3IrqReq}, 16'h0000);
        fin("match");
        // forced matches: clear all, ignored in a PWM mode, set all in clear-on-match mode
        wr(ADDR_FLAG_T3, 8'h3e);
        wrw(ADDR_CNT_HI, ADDR_CNT_LO, 16'h0055);
        wr(ADDR_CTRL_A, 8'ha8);
        wr(ADDR_CTRL_C, 8'he0);
        pause(1);
        check({13'h0000, compareOutputPin}, 16'h0000);
        wr(ADDR_CTRL_A, 8'hfd);
        wr(ADDR_CTRL_C, 8'he0);
        pause(1);
        check({13'h0000, compareOutputPin}, 16'h0000);
        wr(ADDR_CTRL_A, 8'hfc);
        wr(ADDR_CTRL_B, 8'h08);
        wr(ADDR_CTRL_C, 8'he0);
        pause(1);
        check({13'h0000, compareOutputPin}, 16'h0007);
        check({11'h000, t3IrqReq}, 16'h0000);
        rd(ADDR_FLAG_T3, 8'h00);
        rd(ADDR_CNT_LO, 8'h55);
        fin("force");
        // every running internal source counts about four ticks in a window of four periods; stop counts none
        for (int i = 0; i < 6; i++) begin
            wrw(ADDR_CNT_HI, ADDR_CNT_LO, 16'h0000);
            wr(ADDR_CTRL_B, {5'h00, 3'(i)});
            repeat (4 * divs[i] - 2) @(posedge clk);
            wr(ADDR_CTRL_B, 8'h00);
            peek(ADDR_CNT_LO, got);
            check({15'h0000, (i == 0) ? got == 8'h00 : (got >= 8'h03 && got <= 8'h05)}, 16'h0001);
        end
        // three pulses on the count pin give three counts on either edge choice
        for (int e = 0; e < 2; e++) begin
            wrw(ADDR_CNT_HI, ADDR_CNT_LO, 16'h0000);
            wr(ADDR_CTRL_B, {5'h00, e[0] ? CS_EXT_RISE : CS_EXT_FALL});
            repeat (3) begin
                externalCountPin <= 1'b1;
                repeat (4) @(posedge clk);
                externalCountPin <= 1'b0;
                repeat (4) @(posedge clk);
            end
            wr(ADDR_CTRL_B, 8'h00);
            rd(ADDR_CNT_LO, 8'h03);
        end
        fin("clock select");
        // capture from the pin, then from the comparator
        for (int s = 0; s < 2; s++) begin
            val = 16'($random(seed));
            wr(ADDR_FLAG_T3, 8'h3e);
            wrw(ADDR_CNT_HI, ADDR_CNT_LO, val);
            comparatorSelect <= s[0];
            wr(ADDR_CTRL_B, 8'h40);
            if (s == 1) comparatorOut <= 1'b1;
            else capturePin <= 1'b1;
            repeat (6) @(posedge clk);
            rd(ADDR_CAP_LO, val[7:0]);
            rd(ADDR_CAP_HI, val[15:8]);
            rd(ADDR_FLAG_T3, 8'h20);
            comparatorOut <= 1'b0;
            capturePin <= 1'b0;
        end
        fin("capture");
        pause(3);
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
